/* src/cxmf_pkg.sv */
package cxmf_pkg;
  // sleep-entry hold time and i/o-loss sleep delay, in microseconds
  localparam int unsigned GTS_HOLD_US      = 50;
  localparam int unsigned IO_LOSS_SLP_US   = 50;
  // rail-low shutdown delays, in microseconds
  localparam int unsigned BUS_OFF_DLY_US   = 50;
  localparam int unsigned REG_OFF_DLY_US   = 200;
  // low-power exit time before receive output is released
  localparam int unsigned LP_EXIT_US       = 10;
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned GTS_HOLD_CYC     = GTS_HOLD_US * CLK_MHZ;
  localparam int unsigned IO_LOSS_SLP_CYC  = IO_LOSS_SLP_US * CLK_MHZ;
  localparam int unsigned BUS_OFF_DLY_CYC  = BUS_OFF_DLY_US * CLK_MHZ;
  localparam int unsigned REG_OFF_DLY_CYC  = REG_OFF_DLY_US * CLK_MHZ;
  localparam int unsigned LP_EXIT_CYC      = LP_EXIT_US * CLK_MHZ;
  // transmit edges before fault output switches to failure reporting
  localparam logic [2:0]  TX_EDGE_REPORT   = 3'h4;
  // consecutive failing tx cycles for a bus failure
  localparam logic [2:0]  BUS_FAIL_CYCLES  = 3'h5;
  localparam int unsigned TMR_W            = 32;
  localparam logic [1:0]  SLEW_FASTEST     = 2'h0;

  typedef enum {
    CXMF_STANDBY, CXMF_NORMAL, CXMF_LISTEN, CXMF_GOTO_SLEEP, CXMF_SLEEP
  } cxmf_mode_t;
endpackage

/* src/cxmf_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// - normal mode: driver and receiver on, bus follows transmit, rx shows bus
// - both select pins high select normal; entry clears supply-loss flag
// - select pins [0,1] give listen-only: receiver on, driver off
// - listen-only fault shows local/rail-low from normal, supply-loss else
// - pins [1,0] go-to-sleep; no bias; inhibit on; sleep after hold time
// - sleep: regulator off, no bias, inhibit floats; wake goes to standby
// - i/o supply lost longer than its delay forces sleep
// - battery below threshold sets supply-loss and resets all flags
// - bus wake pattern in standby/sleep sets flag; fault and rx low
// - local wake transition in low power sets flag; fault low
// - wake flags clear on leaving normal or on serial read
// - normal before fourth tx pulse: fault low local, high bus wake
// - from fourth tx edge fault reports bus failure and rail-low
// - local failure is or of tx clamp, rx clamp, tx-rx short, rail-low
// - local failure clears on normal entry or tx high with rx low
// - bus failure after five failing tx cycles or clamp; normal clears
// - rail-low sets flag, bus off after delay, regulator off later
// - cold-start hold bit with low battery suppresses rail-low shutdowns
// - rail-low clears in standby/sleep or recovered+read; bus returns on recovery, regulator on mode change
// - standby/sleep to normal/listen: rx held low until ready, then follows bus
// - driver enabled only in normal once transmit is recessive
// - three slew rates by serial config, fastest by default
// - standby first after power-up, full charge then reduced current
// - sleep request ignored until supply-loss and wake flags cleared
module cxmf_ctrl
  import cxmf_pkg::*;
(
  input  wire logic       clk_sys,           // 125 mhz clock
  input  wire logic       resetn,            // async reset, power-on
  input  wire logic       enable_pin,        // primary mode select
  input  wire logic       mode_select_low_active, // standby select, low act
  input  wire logic       txd,               // transmit level from mcu
  input  wire logic       bus_rx_dominant,   // receiver sees dominant bus
  input  wire logic       bus_wake_pattern,  // valid bus wake pattern
  input  wire logic       wake_pin,          // local wake input
  input  wire logic       battery_supply_low, // below supply_loss_threshold
  input  wire logic       battery_uv,        // below undervoltage level
  input  wire logic       io_supply_rail_low, // i/o supply below threshold
  input  wire logic       rail_low,          // internal rail under threshold
  input  wire logic       bus_short_det,     // short seen in a tx cycle
  input  wire logic       bus_dom_clamp,     // bus dominant clamp
  input  wire logic       tx_dom_clamp,      // transmit dominant clamp
  input  wire logic       rx_rec_clamp,      // receive recessive clamp
  input  wire logic       tx_rx_short,       // transmit-receive short
  input  wire logic       crank_hold,        // cold-start hold bit
  input  wire logic       flag_read,         // serial read of flags
  input  wire logic       slew_wr,           // serial slew write strobe
  input  wire logic [1:0] slew_wdata,        // slew select value
  output logic            rxd,               // receive output to mcu
  output logic            err_n,             // fault output, active low
  output logic            drv_en,            // bus driver enable
  output logic            drv_dominant,      // drive bus dominant
  output logic            rcv_en,            // bus receiver enable
  output logic            split_en,          // midpoint bias enable
  output logic            reg_on,            // rail regulator on
  output logic            reg_full,          // regulator full current
  output logic            ext_regulator_control_oe, // inhibit driven high
  output logic [1:0]      slew_sel,          // selected slew rate
  output cxmf_pkg::cxmf_mode_t mode         // current mode
);
  import cxmf_pkg::*;

  logic [6:0] sync1_q, sync2_q;
  logic en_s, mode_select_low_active_s, tx_s, wk_s;
  logic batl_s, io_low_s, vdd_low_s;
  logic wk_prev_q, tx_prev_q;

  // two-stage synchronisers for pin inputs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // txd resets recessive so no false edge follows reset
      sync1_q <= 7'h10;
      sync2_q <= 7'h10;
    end else begin
      sync1_q <= {enable_pin, mode_select_low_active, txd, wake_pin,
                  battery_supply_low, io_supply_rail_low, rail_low};
      sync2_q <= sync1_q;
    end
  end
  assign {en_s, mode_select_low_active_s, tx_s, wk_s, batl_s, io_low_s, vdd_low_s} = sync2_q;

  cxmf_mode_t mode_q, mode_d, prev_q;
  logic batfail_q, bus_wu_q, loc_wu_q, loc_fail_q, bus_fail_q, vdd_low_q;
  logic [2:0] tx_edges_q, fail_cyc_q;
  logic [TMR_W-1:0] gts_cnt_q, io_cnt_q, vdd_cnt_q, lp_cnt_q;
  logic lp_exit_q, can_off_q, reg_off_q, charged_q;
  logic uv_prev_q;
  logic wake_any, sleep_ok, suppress;

  assign wake_any = bus_wu_q | loc_wu_q;
  assign sleep_ok = !batfail_q && !wake_any;
  assign suppress = crank_hold && battery_uv;

  // sleep ignores the pins; only a wake flag or battery low leaves it
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      CXMF_SLEEP: begin
        if (wake_any) mode_d = CXMF_STANDBY;
      end
      default: begin
        case ({en_s, mode_select_low_active_s})
          2'b11: mode_d = CXMF_NORMAL;
          2'b01: mode_d = CXMF_LISTEN;
          2'b10: begin
            if (mode_q == CXMF_GOTO_SLEEP && wake_any)
              mode_d = CXMF_STANDBY;
            else if (mode_q == CXMF_GOTO_SLEEP &&
                     gts_cnt_q >= TMR_W'(GTS_HOLD_CYC) && sleep_ok)
              mode_d = CXMF_SLEEP;
            else if (mode_q != CXMF_GOTO_SLEEP)
              mode_d = CXMF_GOTO_SLEEP;
          end
          default: mode_d = CXMF_STANDBY;
        endcase
      end
    endcase
    if (io_cnt_q >= TMR_W'(IO_LOSS_SLP_CYC) && sleep_ok)
      mode_d = CXMF_SLEEP;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q <= CXMF_STANDBY;
      prev_q <= CXMF_STANDBY;
    end else if (batl_s) begin
      mode_q <= CXMF_STANDBY;
      prev_q <= CXMF_STANDBY;
    end else begin
      mode_q <= mode_d;
      if (mode_d != mode_q) prev_q <= mode_q;
    end
  end

  // hold timers for sleep entry and i/o loss
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gts_cnt_q <= '0;
      io_cnt_q  <= '0;
    end else begin
      gts_cnt_q <= (mode_q == CXMF_GOTO_SLEEP && mode_d == CXMF_GOTO_SLEEP)
                   ? gts_cnt_q + 1'b1 : '0;
      io_cnt_q  <= (io_low_s && mode_q != CXMF_SLEEP)
                   ? io_cnt_q + 1'b1 : '0;
    end
  end

  logic entering_normal, leaving_normal;
  assign entering_normal = mode_d == CXMF_NORMAL && mode_q != CXMF_NORMAL;
  assign leaving_normal  = mode_q == CXMF_NORMAL && mode_d != CXMF_NORMAL;

  // wake flags; a set beats a leave-normal or read clear in the same cycle, battery low beats a set
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bus_wu_q  <= 1'b0;
      loc_wu_q  <= 1'b0;
      wk_prev_q <= 1'b0;
    end else begin
      wk_prev_q <= wk_s;
      if (batl_s) begin
        bus_wu_q <= 1'b0;
        loc_wu_q <= 1'b0;
      end else begin
        if (bus_wake_pattern &&
            (mode_q == CXMF_STANDBY || mode_q == CXMF_SLEEP))
          bus_wu_q <= 1'b1;
        else if (leaving_normal || flag_read)
          bus_wu_q <= 1'b0;
        if (wk_s != wk_prev_q && mode_q != CXMF_NORMAL &&
            mode_q != CXMF_LISTEN)
          loc_wu_q <= 1'b1;
        else if (leaving_normal || flag_read)
          loc_wu_q <= 1'b0;
      end
    end
  end

  // power-up counts as a supply loss
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) batfail_q <= 1'b1;
    else if (batl_s) batfail_q <= 1'b1;
    else if (entering_normal) batfail_q <= 1'b0;
  end

  // transmit edge count and bus failure qualification
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_prev_q  <= 1'b1;
      tx_edges_q <= 3'h0;
      fail_cyc_q <= 3'h0;
      bus_fail_q <= 1'b0;
    end else begin
      tx_prev_q <= tx_s;
      if (batl_s || entering_normal) begin
        tx_edges_q <= 3'h0;
        fail_cyc_q <= 3'h0;
        bus_fail_q <= 1'b0;
      end else begin
        if (mode_q == CXMF_NORMAL && tx_s && !tx_prev_q) begin
          if (tx_edges_q != TX_EDGE_REPORT)
            tx_edges_q <= tx_edges_q + 3'h1;
          if (!bus_short_det) fail_cyc_q <= 3'h0;
          else if (fail_cyc_q != BUS_FAIL_CYCLES)
            fail_cyc_q <= fail_cyc_q + 3'h1;
        end
        if (fail_cyc_q == BUS_FAIL_CYCLES || bus_dom_clamp)
          bus_fail_q <= 1'b1;
      end
    end
  end

  // a failure still present beats the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) loc_fail_q <= 1'b0;
    else if (batl_s) loc_fail_q <= 1'b0;
    else if (tx_dom_clamp || rx_rec_clamp || tx_rx_short || vdd_low_s)
      loc_fail_q <= 1'b1;
    else if (entering_normal || (tx_s && !rxd))
      loc_fail_q <= 1'b0;
  end

  // rail-low flag and shutdown timers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      vdd_low_q <= 1'b0;
      vdd_cnt_q <= '0;
      can_off_q <= 1'b0;
      reg_off_q <= 1'b0;
      uv_prev_q <= 1'b0;
    end else begin
      uv_prev_q <= battery_uv;
      if (batl_s || mode_q == CXMF_SLEEP || mode_q == CXMF_STANDBY)
        vdd_low_q <= 1'b0;
      else if (vdd_low_s)
        vdd_low_q <= 1'b1;
      else if (flag_read)
        vdd_low_q <= 1'b0;
      vdd_cnt_q <= (vdd_low_s && !suppress &&
                    (mode_q == CXMF_NORMAL || mode_q == CXMF_LISTEN))
                   ? vdd_cnt_q + 1'b1 : '0;
      if (vdd_cnt_q >= TMR_W'(BUS_OFF_DLY_CYC)) can_off_q <= 1'b1;
      else if (!vdd_low_s) can_off_q <= 1'b0;
      if (vdd_cnt_q >= TMR_W'(REG_OFF_DLY_CYC)) reg_off_q <= 1'b1;
      // regulator returns on battery recovery or on a mode change
      else if (batl_s || (uv_prev_q && !battery_uv) || mode_d != mode_q)
        reg_off_q <= 1'b0;
    end
  end

  // low-power exit hold and power-up charge phase
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lp_exit_q <= 1'b0;
      lp_cnt_q  <= '0;
      charged_q <= 1'b0;
    end else begin
      if ((mode_d == CXMF_NORMAL || mode_d == CXMF_LISTEN) &&
          (mode_q == CXMF_SLEEP || mode_q == CXMF_STANDBY)) begin
        lp_exit_q <= 1'b1;
        lp_cnt_q  <= '0;
      end else if (lp_exit_q) begin
        lp_cnt_q <= lp_cnt_q + 1'b1;
        if (lp_cnt_q >= TMR_W'(LP_EXIT_CYC)) lp_exit_q <= 1'b0;
      end
      // charge phase ends on the first settled cycle
      if (!charged_q && lp_cnt_q == '0 && !lp_exit_q)
        charged_q <= 1'b1;
    end
  end

  // driver arms on a recessive txd in normal
  logic drv_arm_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) drv_arm_q <= 1'b0;
    else if (mode_q != CXMF_NORMAL || can_off_q) drv_arm_q <= 1'b0;
    else if (tx_s) drv_arm_q <= 1'b1;
  end

  // code 3 selects no rate and is dropped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) slew_sel <= SLEW_FASTEST;
    else if (batl_s) slew_sel <= SLEW_FASTEST;
    else if (slew_wr && slew_wdata != 2'h3) slew_sel <= slew_wdata;
  end

  // output registers
  logic err_d, rxd_d, low_pwr;
  assign low_pwr = mode_q == CXMF_STANDBY || mode_q == CXMF_SLEEP ||
                   mode_q == CXMF_GOTO_SLEEP;
  // fault source depends on mode and on the mode it came from
  always_comb begin
    err_d = 1'b1;
    rxd_d = 1'b1;
    case (mode_q)
      CXMF_NORMAL: begin
        rxd_d = !bus_rx_dominant;
        if (tx_edges_q != TX_EDGE_REPORT)
          err_d = !loc_wu_q;
        else
          err_d = !(bus_fail_q || vdd_low_q);
      end
      CXMF_LISTEN: begin
        rxd_d = !bus_rx_dominant;
        if (prev_q == CXMF_NORMAL)
          err_d = !(loc_fail_q || vdd_low_q);
        else
          err_d = !batfail_q;
      end
      default: begin
        if (mode_q != CXMF_SLEEP || !io_low_s) begin
          err_d = !wake_any;
          rxd_d = !bus_wu_q;
        end
      end
    endcase
    if (lp_exit_q) rxd_d = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxd   <= 1'b1;
      err_n <= 1'b1;
    end else begin
      rxd   <= rxd_d;
      err_n <= err_d;
    end
  end

  assign mode         = mode_q;
  // gated by mode too, so the driver drops in the edge that leaves normal
  assign drv_en       = drv_arm_q && mode_q == CXMF_NORMAL &&
                        !can_off_q;
  assign drv_dominant = drv_en && !tx_s;
  assign rcv_en       = (mode_q == CXMF_NORMAL ||
                         mode_q == CXMF_LISTEN) && !can_off_q;
  assign split_en     = mode_q == CXMF_NORMAL || mode_q == CXMF_LISTEN;
  assign reg_on       = mode_q != CXMF_SLEEP && !reg_off_q;
  assign reg_full     = reg_on && (!low_pwr || !charged_q ||
                        mode_q == CXMF_GOTO_SLEEP);
  assign ext_regulator_control_oe = mode_q != CXMF_SLEEP;
endmodule // cxmf_ctrl

/* tb/cxmf_ctrl_properties.sv */
`timescale 1ns/1ps
module cxmf_ctrl_checker
  import cxmf_pkg::*;
(
  input wire logic             clk_sys,                  // clock
  input wire logic             resetn,                   // reset
  input wire logic             enable_pin,               // mode pin
  input wire logic             mode_select_low_active,   // mode pin
  input wire logic             io_supply_rail_low,       // i/o low
  input wire logic             battery_supply_low,       // battery low
  input wire logic             slew_wr,                  // slew strobe
  input wire logic [1:0]       slew_wdata,               // slew value
  input wire logic             rxd,                      // receive out
  input wire logic             drv_en,                   // driver on
  input wire logic             rcv_en,                   // receiver on
  input wire logic             split_en,                 // bias on
  input wire logic             reg_on,                   // regulator on
  input wire logic             ext_regulator_control_oe, // inhibit
  input wire logic [1:0]       slew_sel,                 // slew rate
  input cxmf_pkg::cxmf_mode_t  mode                      // mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire quiet = !io_supply_rail_low && !battery_supply_low;
  wire pins_n = enable_pin && mode_select_low_active && quiet;
  wire pins_l = !enable_pin && mode_select_low_active && quiet;
  a_drv_needs_normal: assert property (
    drv_en |-> mode == CXMF_NORMAL) else $error("driver on off normal");
  a_listen_rx_only: assert property (
    mode == CXMF_LISTEN |-> rcv_en && !drv_en)
    else $error("listen enables wrong");
  a_lowpwr_no_bias: assert property (
    mode inside {CXMF_GOTO_SLEEP, CXMF_SLEEP} |-> !split_en)
    else $error("bias on in low power");
  a_gts_inh_on: assert property (
    mode == CXMF_GOTO_SLEEP |-> ext_regulator_control_oe)
    else $error("inhibit off in go-to-sleep");
  a_sleep_all_off: assert property (
    mode == CXMF_SLEEP |-> !reg_on && !ext_regulator_control_oe)
    else $error("sleep outputs wrong");
  a_normal_entry: assert property (
    pins_n [*8] |-> mode == CXMF_NORMAL) else $error("normal not entered");
  a_listen_entry: assert property (
    pins_l [*8] |-> mode == CXMF_LISTEN) else $error("listen not entered");
  a_lp_exit_rx: assert property (
    $past(mode) == CXMF_STANDBY && mode inside {CXMF_NORMAL, CXMF_LISTEN}
    |=> !rxd) else $error("rx not held low on exit");
  a_slew_hold: assert property (
    (!slew_wr && !battery_supply_low) [*4] |=> $stable(slew_sel))
    else $error("slew changed without write");
  a_slew_write: assert property (
    slew_wr && slew_wdata != 2'h3 |=> slew_sel == $past(slew_wdata))
    else $error("slew write lost");
  c_sleep: cover property (mode == CXMF_SLEEP);
  c_wake: cover property ($past(mode) == CXMF_SLEEP && mode == CXMF_STANDBY);
  c_listen_low: cover property (mode == CXMF_LISTEN && !rxd);
endmodule // cxmf_ctrl_checker

/* tb/cxmf_mcu_model.sv */
`timescale 1ns/1ps
module cxmf_mcu_model (
  input  wire logic  clk_sys,                // clock
  output logic       enable_pin,             // mode select
  output logic       mode_select_low_active, // standby select
  output logic       txd,                    // transmit level
  output logic       flag_read,              // flag read pulse
  output logic       slew_wr,                // slew write pulse
  output logic [1:0] slew_wdata              // slew value
);
  initial begin
    {enable_pin, mode_select_low_active, txd} = 3'h1;
    {flag_read, slew_wr, slew_wdata} = 4'h0;
  end
  // static levels, held until the next change
  task automatic pins(input logic en, input logic sb);
    @(negedge clk_sys);
    enable_pin = en;
    mode_select_low_active = sb;
  endtask
  task automatic level(input logic v);
    @(negedge clk_sys);
    txd = v;
  endtask
  // dominant then recessive, w cycles each; idle recessive
  task automatic pulses(input int n, input int w);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys) txd = 1'b0;
      repeat (w) @(negedge clk_sys);
      txd = 1'b1;
      repeat (w) @(negedge clk_sys);
    end
  endtask
  task automatic slew(input logic [1:0] v);
    @(negedge clk_sys);
    slew_wr = 1'b1;
    slew_wdata = v;
    @(negedge clk_sys);
    slew_wr = 1'b0;
  endtask
  task automatic read_flags;
    @(negedge clk_sys) flag_read = 1'b1;
    @(negedge clk_sys) flag_read = 1'b0;
  endtask
endmodule // cxmf_mcu_model

/* tb/test_can_transceiver_mode_flag_control.sv */
`timescale 1ns/1ps
module test_can_transceiver_mode_flag_control;
  import cxmf_pkg::*;
  logic       clk_sys, resetn, bus_rx_dominant, bus_wake_pattern, wake_pin;
  logic       battery_supply_low, rail_low, bus_short_det, tx_dom_clamp;
  logic       tx_rx_short, enable_pin, mode_select_low_active, txd;
  logic       flag_read, slew_wr, rxd, err_n, drv_en, drv_dominant;
  logic       rcv_en, split_en, reg_on, reg_full, ext_regulator_control_oe;
  logic [1:0] slew_wdata, slew_sel, ex;
  logic       io_supply_rail_low;
  logic [1:0] sv [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  cxmf_mode_t mode;
  int         errors, total_checks, w;
  int         cyc = 0;

  cxmf_mcu_model i_mcu (.clk_sys, .enable_pin, .mode_select_low_active,
    .txd, .flag_read, .slew_wr, .slew_wdata);
  cxmf_ctrl i_dut (.clk_sys, .resetn, .enable_pin, .mode_select_low_active,
    .txd, .bus_rx_dominant, .bus_wake_pattern, .wake_pin,
    .battery_supply_low, .battery_uv(1'b0), .io_supply_rail_low,
    .rail_low, .bus_short_det, .bus_dom_clamp(1'b0), .tx_dom_clamp,
    .rx_rec_clamp(1'b0), .tx_rx_short, .crank_hold(1'b0), .flag_read,
    .slew_wr, .slew_wdata, .rxd, .err_n, .drv_en, .drv_dominant, .rcv_en,
    .split_en, .reg_on, .reg_full, .ext_regulator_control_oe, .slew_sel,
    .mode);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic inv(input logic v);
    return !v;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic go(input logic en, input logic sb);
    i_mcu.pins(en, sb);
    cyc_n(6);
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    {resetn, bus_rx_dominant, bus_wake_pattern, wake_pin} = 4'h0;
    {battery_supply_low, rail_low, bus_short_det, io_supply_rail_low} = 4'h0;
    {tx_dom_clamp, tx_rx_short} = 2'h0;
    errors = 0;
    total_checks = 0;
    void'($urandom(1));
    cyc_n(4);
    resetn = 1'b1;
    cyc_n(2);
    chk(mode, CXMF_STANDBY);
    chk({rxd, err_n, slew_sel}, {2'h3, SLEW_FASTEST});
    go(1'b0, 1'b1);
    chk(mode, CXMF_LISTEN);
    chk({rxd, err_n, drv_en}, 3'h0);
    cyc_n(LP_EXIT_CYC + 10);
    chk(rxd, 1'b1);
    go(1'b1, 1'b1);
    chk({mode == CXMF_NORMAL, err_n}, 2'h3);
    for (int i = 0; i < 16; i++) begin
      i_mcu.level(1'($urandom_range(1)));
      bus_rx_dominant = 1'($urandom_range(1));
      cyc_n(5);
      chk({drv_en, drv_dominant, rxd},
          {1'b1, inv(txd), inv(bus_rx_dominant)});
    end
    i_mcu.level(1'b1);
    bus_rx_dominant = 1'b0;
    ex = SLEW_FASTEST;
    foreach (sv[i]) begin
      i_mcu.slew(sv[i]);
      if (sv[i] != 2'h3) ex = sv[i];
      chk(slew_sel, ex);
    end
    go(1'b0, 1'b0);
    go(1'b1, 1'b1);
    cyc_n(LP_EXIT_CYC);
    bus_short_det = 1'b1;
    w = 3 + $urandom_range(7);
    i_mcu.pulses(4, w);
    cyc_n(4);
    chk(err_n, 1'b1);
    i_mcu.pulses(1, w);
    cyc_n(4);
    chk(err_n, 1'b0);
    bus_short_det = 1'b0;
    go(1'b0, 1'b0);
    go(1'b1, 1'b1);
    cyc_n(LP_EXIT_CYC);
    i_mcu.pulses(4, 3 + $urandom_range(7));
    cyc_n(4);
    chk(err_n, 1'b1);
    {tx_dom_clamp, tx_rx_short} = 2'h3;
    cyc_n(4);
    go(1'b0, 1'b1);
    chk(err_n, 1'b0);
    {tx_dom_clamp, tx_rx_short} = 2'h0;
    go(1'b0, 1'b0);
    wake_pin = 1'b1;
    cyc_n(5);
    chk(err_n, 1'b0);
    go(1'b1, 1'b1);
    cyc_n(LP_EXIT_CYC);
    chk(err_n, 1'b0);
    go(1'b0, 1'b0);
    chk(err_n, 1'b1);
    bus_wake_pattern = 1'b1;
    cyc_n(2);
    bus_wake_pattern = 1'b0;
    cyc_n(4);
    chk({err_n, rxd}, 2'h0);
    go(1'b1, 1'b1);
    cyc_n(LP_EXIT_CYC);
    chk(err_n, 1'b1);
    go(1'b0, 1'b0);
    battery_supply_low = 1'b1;
    cyc_n(8);
    battery_supply_low = 1'b0;
    go(1'b1, 1'b0);
    cyc_n(GTS_HOLD_CYC + 20);
    chk(mode, CXMF_GOTO_SLEEP);
    go(1'b1, 1'b1);
    go(1'b1, 1'b0);
    cyc_n(GTS_HOLD_CYC + 20);
    chk(mode, CXMF_SLEEP);
    chk({reg_on, ext_regulator_control_oe}, 2'h0);
    i_mcu.pins(1'b0, 1'b0);
    wake_pin = 1'b0;
    cyc_n(6);
    chk(mode, CXMF_STANDBY);
    go(1'b1, 1'b1);
    cyc_n(LP_EXIT_CYC);
    i_mcu.pulses(4, 3 + $urandom_range(7));
    cyc_n(4);
    rail_low = 1'b1;
    cyc_n(6);
    chk(err_n, 1'b0);
    cyc_n(BUS_OFF_DLY_CYC + 20);
    chk({drv_en, reg_on}, 2'h1);
    cyc_n(REG_OFF_DLY_CYC - BUS_OFF_DLY_CYC + 20);
    chk(reg_on, 1'b0);
    rail_low = 1'b0;
    cyc_n(6);
    chk({drv_en, reg_on}, 2'h2);
    i_mcu.read_flags();
    cyc_n(4);
    chk(err_n, 1'b1);
    go(1'b0, 1'b0);
    chk(reg_on, 1'b1);
    io_supply_rail_low = 1'b1;
    cyc_n(IO_LOSS_SLP_CYC + 20);
    chk({mode == CXMF_SLEEP, err_n, rxd}, 3'h7);
    tally_and_finish();
  end
endmodule // test_can_transceiver_mode_flag_control

bind cxmf_ctrl cxmf_ctrl_checker i_chk (.clk_sys, .resetn, .enable_pin,
  .mode_select_low_active, .io_supply_rail_low, .battery_supply_low,
  .slew_wr, .slew_wdata, .rxd, .drv_en, .rcv_en, .split_en, .reg_on,
  .ext_regulator_control_oe, .slew_sel, .mode);
